// File: verilog/tmcc_pkg.sv
// What this block does
// - Compare counter with each comparator; a match flags, may clear counter, may move pin.
// - Three-bit field picks counter clock: system ratios, high clock, subsidiary, or pin.
// - External clock pin counts on rising or falling edge as configured.
// - Standard/periodic: external clock pin triggers single pulse output mode.
// - Standard/periodic types have separate match interrupts for comparators A and P.
// - Audio type has comparators A, B and P, each with its own interrupt.
// - Capture pin captures on rising, falling or both edges, chosen by two bits.
// - Periodic type may take external clock pin as alternative capture source.
// - Two output pins; the second is always the inverse of the first.
// - Compare output mode sets, clears or toggles primary pin on match.
// - PWM waveform appears on the same primary output pin.
// - Timer, capture, compare, single pulse, PWM; audio type lacks capture and pulse.
// - PWM is edge aligned; comparators set either duty or period, not both.
// - Counter and comparators A and B appear as byte pairs, P as one byte; low bytes go through a buffer.
// - Writing a comparator low byte loads only the holding buffer.
// - Writing a comparator high byte loads it and moves buffer into low byte.
// - Reading a high byte returns it and copies the live low byte to buffer.
// - Reading a low byte returns the holding buffer.
// - Counter is sixteen bits counting up; comparator P matches its upper byte.
// - Counter clears on run rising, holds when stopped, clears on overflow or match.
package tmcc_pkg;
    localparam logic [3:0] TMCC_ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] TMCC_ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] TMCC_ADDR_CNT_L = 4'h2;
    localparam logic [3:0] TMCC_ADDR_CNT_H = 4'h3;
    localparam logic [3:0] TMCC_ADDR_A_L = 4'h4;
    localparam logic [3:0] TMCC_ADDR_A_H = 4'h5;
    localparam logic [3:0] TMCC_ADDR_B_L = 4'h6;
    localparam logic [3:0] TMCC_ADDR_B_H = 4'h7;
    localparam logic [3:0] TMCC_ADDR_P = 4'h8;
    localparam logic [3:0] TMCC_ADDR_FLAGS = 4'h9;
    localparam logic [3:0] TMCC_ADDR_CTRL2 = 4'ha;
    // Control 0 fields
    localparam int TMCC_C0_PAUSE = 7;
    localparam int TMCC_C0_CKS_LO = 4;
    localparam int TMCC_C0_RUN = 3;
    // Control 1 fields
    localparam int TMCC_C1_MODE_LO = 6;
    localparam int TMCC_C1_ACT_LO = 4;
    localparam int TMCC_C1_INIT = 3;
    localparam int TMCC_C1_POL = 2;
    localparam int TMCC_C1_DPX = 1;
    localparam int TMCC_C1_CCLR = 0;
    // Flag bit positions
    localparam int TMCC_FLAG_A = 0;
    localparam int TMCC_FLAG_B = 1;
    localparam int TMCC_FLAG_P = 2;
    localparam logic [7:0] TMCC_RST_BYTE = 8'h00;
    localparam logic [15:0] TMCC_RST_WORD = 16'h0000;
    // Prescaler terminal counts
    localparam logic [1:0] TMCC_DIV4_LAST = 2'h3;
    localparam logic [3:0] TMCC_DIV16_LAST = 4'hf;
    localparam logic [5:0] TMCC_DIV64_LAST = 6'h3f;
    localparam int TMCC_SUB_DIV_DEFAULT = 1220;
    typedef enum logic [1:0] {
        TMCC_MODE_CMP = 2'b00,
        TMCC_MODE_CAP = 2'b01,
        TMCC_MODE_PWM = 2'b10,
        TMCC_MODE_TMR = 2'b11
    } tmcc_mode_t;
    typedef enum logic [2:0] {
        TMCC_CK_SYS4 = 3'b000,
        TMCC_CK_SYS = 3'b001,
        TMCC_CK_H16 = 3'b010,
        TMCC_CK_H64 = 3'b011,
        TMCC_CK_SUB0 = 3'b100,
        TMCC_CK_SUB1 = 3'b101,
        TMCC_CK_PINR = 3'b110,
        TMCC_CK_PINF = 3'b111
    } tmcc_cks_t;
endpackage

// File: verilog/tmcc_core.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tmcc_core
    import tmcc_pkg::*;
#(
    parameter bit AUDIO_TYPE = 1'b0,
    parameter bit PERIODIC_TYPE = 1'b0,
    parameter int SUB_DIV = TMCC_SUB_DIV_DEFAULT
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic external_clock_pin_i,
    input wire logic capture_input_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_inverted_pin_o,
    output logic [2:0] match_flag_o
);
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [7:0] ctrl1_r;
    logic run_r, pause_r, run_q_r, alt_cap_r;
    logic [2:0] cks_r;
    logic [15:0] cnt_r, cmp_a_r, cmp_b_r;
    logic [7:0] cmp_p_r, hold_r, rdata_r;
    logic [2:0] flag_r;
    logic pin_r, out_r, out_n_r;
    logic [1:0] ext_sync_r, cap_sync_r;
    logic ext_q_r, cap_q_r;
    logic [1:0] div4_r;
    logic [5:0] div64_r;
    logic [15:0] sub_cnt_r;
    logic tick, run_rise, count_en, ext_rise, ext_fall, cap_rise, cap_fall;
    logic cap_src_rise, cap_src_fall, cap_ev, trig_ev, sp_mode, pwm_mode;
    logic eq_a, eq_b, eq_p, ev_a, ev_b, ev_p, clr_ev, per_ev, duty_ev;
    logic [1:0] mode, act;
    logic wr_c0, wr_c1, wr_flags, wr_c2;

    // Register write strobe decode
    function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] ref_a);
        hit = strobe && (a == ref_a);
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    assign mode = ctrl1_r[TMCC_C1_MODE_LO +: 2];
    assign act = ctrl1_r[TMCC_C1_ACT_LO +: 2];
    assign pwm_mode = (mode == TMCC_MODE_PWM);
    assign sp_mode = pwm_mode && (act == 2'b11) && !AUDIO_TYPE;
    assign wr_c0 = hit(wr_i, addr_i, TMCC_ADDR_CTRL0);
    assign wr_c1 = hit(wr_i, addr_i, TMCC_ADDR_CTRL1);
    assign wr_flags = hit(wr_i, addr_i, TMCC_ADDR_FLAGS);
    assign wr_c2 = hit(wr_i, addr_i, TMCC_ADDR_CTRL2);

    // Pin synchronisers and edge history
    // two-flop synchronise
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sync_r <= 2'b00;
            cap_sync_r <= 2'b00;
            ext_q_r <= 1'b0;
            cap_q_r <= 1'b0;
        end
        else
        begin
            ext_sync_r <= {ext_sync_r[0], external_clock_pin_i};
            cap_sync_r <= {cap_sync_r[0], capture_input_pin_i};
            ext_q_r <= ext_sync_r[1];
            cap_q_r <= cap_sync_r[1];
        end
    end
    assign ext_rise = ext_sync_r[1] && !ext_q_r;
    assign ext_fall = !ext_sync_r[1] && ext_q_r;
    assign cap_rise = cap_sync_r[1] && !cap_q_r;
    assign cap_fall = !cap_sync_r[1] && cap_q_r;

    // Prescalers for the internal clock ratios
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div4_r <= 2'h0;
            div64_r <= 6'h00;
            sub_cnt_r <= TMCC_RST_WORD;
        end
        else
        begin
            div4_r <= div4_r + 2'h1;
            div64_r <= div64_r + 6'h01;
            if (sub_cnt_r == 16'(SUB_DIV - 1))
                sub_cnt_r <= TMCC_RST_WORD;
            else
                sub_cnt_r <= sub_cnt_r + 16'h0001;
        end
    end

    // Counter clock enable selection
    // clock source select
    always_comb
    begin
        unique case (tmcc_cks_t'(cks_r))
            TMCC_CK_SYS4: tick = (div4_r == TMCC_DIV4_LAST);
            TMCC_CK_SYS: tick = 1'b1;
            TMCC_CK_H16: tick = (div64_r[3:0] == TMCC_DIV16_LAST);
            TMCC_CK_H64: tick = (div64_r == TMCC_DIV64_LAST);
            TMCC_CK_SUB0,
            TMCC_CK_SUB1: tick = (sub_cnt_r == TMCC_RST_WORD);
            TMCC_CK_PINR: tick = ext_rise;
            TMCC_CK_PINF: tick = ext_fall;
        endcase
    end

    assign run_rise = run_r && !run_q_r;
    assign count_en = run_r && !pause_r && tick;

    // Comparator equality and match events
    // compare against presets
    assign eq_a = (cnt_r == cmp_a_r);
    assign eq_b = AUDIO_TYPE && (cnt_r == cmp_b_r);
    assign eq_p = (cnt_r[15:8] == cmp_p_r);
    assign ev_a = count_en && eq_a;
    assign ev_b = count_en && eq_b;
    assign ev_p = count_en && eq_p;

    // PWM roles of the comparators
    // duty or period select
    assign per_ev = ctrl1_r[TMCC_C1_DPX] ? ev_a : ev_p;
    assign duty_ev = ctrl1_r[TMCC_C1_DPX] ? ev_p : ev_a;

    // Which match clears the counter
    always_comb
    begin
        if (pwm_mode && (act == 2'b10))
            clr_ev = per_ev;
        else if (sp_mode)
            clr_ev = ev_a;
        else
            clr_ev = ctrl1_r[TMCC_C1_CCLR] ? ev_a : ev_p;
    end

    // Capture source and edge qualification
    // alternate capture source
    assign cap_src_rise = (PERIODIC_TYPE && alt_cap_r) ? ext_rise : cap_rise;
    assign cap_src_fall = (PERIODIC_TYPE && alt_cap_r) ? ext_fall : cap_fall;
    always_comb
    begin
        unique case (act)
            2'b00: cap_ev = cap_src_rise;
            2'b01: cap_ev = cap_src_fall;
            2'b10: cap_ev = cap_src_rise || cap_src_fall;
            2'b11: cap_ev = 1'b0;
        endcase
        if (AUDIO_TYPE || (mode != TMCC_MODE_CAP) || !run_r)
            cap_ev = 1'b0;
    end

    assign trig_ev = sp_mode && ext_rise && !run_r;

    // Control registers; single pulse end stops the counter
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_r <= 1'b0;
            pause_r <= 1'b0;
            cks_r <= 3'b000;
            ctrl1_r <= TMCC_RST_BYTE;
            alt_cap_r <= 1'b0;
            run_q_r <= 1'b0;
        end
        else
        begin
            run_q_r <= run_r;
            if (wr_c0)
            begin
                pause_r <= wdata_i[TMCC_C0_PAUSE];
                cks_r <= wdata_i[TMCC_C0_CKS_LO +: 3];
                run_r <= wdata_i[TMCC_C0_RUN];
            end
            else if (trig_ev)
                run_r <= 1'b1;
            else if (sp_mode && ev_a)
                run_r <= 1'b0;
            if (wr_c1)
                ctrl1_r <= wdata_i;
            if (wr_c2)
                alt_cap_r <= wdata_i[0];
        end
    end

    // Free running counter
    // clear on run rise
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= TMCC_RST_WORD;
        else if (run_rise)
            cnt_r <= TMCC_RST_WORD;
        else if (count_en)
        begin
            if (clr_ev)
                cnt_r <= TMCC_RST_WORD;
            else
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    // Sticky match flags, write one to clear
    // set wins over clear
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            flag_r <= 3'b000;
        else
        begin
            if (wr_flags)
                flag_r <= flag_r & ~wdata_i[2:0] | {ev_p, ev_b, ev_a};
            else
                flag_r <= flag_r | {ev_p, ev_b, ev_a};
        end
    end
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            match_flag_o <= 3'b000;
        else
            match_flag_o <= flag_r;
    end

    // Comparator registers, capture and holding buffer
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_a_r <= TMCC_RST_WORD;
            cmp_b_r <= TMCC_RST_WORD;
            cmp_p_r <= TMCC_RST_BYTE;
            hold_r <= TMCC_RST_BYTE;
        end
        else
        begin
            if (cap_ev)
                cmp_a_r <= cnt_r;
            if (wr_i)
            begin
                unique case (addr_i)
                    TMCC_ADDR_A_L,
                    TMCC_ADDR_B_L: hold_r <= wdata_i;
                    TMCC_ADDR_A_H: cmp_a_r <= {wdata_i, hold_r};
                    TMCC_ADDR_B_H: cmp_b_r <= {wdata_i, hold_r};
                    TMCC_ADDR_P: cmp_p_r <= wdata_i;
                    default: ;
                endcase
            end
            else if (rd_i)
            begin
                unique case (addr_i)
                    TMCC_ADDR_CNT_H: hold_r <= cnt_r[7:0];
                    TMCC_ADDR_A_H: hold_r <= cmp_a_r[7:0];
                    TMCC_ADDR_B_H: hold_r <= cmp_b_r[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Read data, valid the cycle after the strobe
    // byte pair access
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_r <= TMCC_RST_BYTE;
        else if (rd_i)
        begin
            unique case (addr_i)
                TMCC_ADDR_CTRL0: rdata_r <= {pause_r, cks_r, run_r, 3'b000};
                TMCC_ADDR_CTRL1: rdata_r <= ctrl1_r;
                TMCC_ADDR_CNT_L,
                TMCC_ADDR_A_L,
                TMCC_ADDR_B_L: rdata_r <= hold_r;
                TMCC_ADDR_CNT_H: rdata_r <= cnt_r[15:8];
                TMCC_ADDR_A_H: rdata_r <= cmp_a_r[15:8];
                TMCC_ADDR_B_H: rdata_r <= cmp_b_r[15:8];
                TMCC_ADDR_P: rdata_r <= cmp_p_r;
                TMCC_ADDR_FLAGS: rdata_r <= {5'b00000, flag_r};
                TMCC_ADDR_CTRL2: rdata_r <= {7'b0000000, alt_cap_r};
                default: rdata_r <= TMCC_RST_BYTE;
            endcase
        end
        else
            rdata_r <= TMCC_RST_BYTE;
    end
    assign rdata_o = rdata_r;

    // Primary pin state machine per mode
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pin_r <= 1'b0;
        else if (mode == TMCC_MODE_CMP)
        begin
            if (run_rise)
                pin_r <= ctrl1_r[TMCC_C1_INIT];
            else if (ev_a)
            begin
                unique case (act)
                    2'b00: pin_r <= pin_r;
                    2'b01: pin_r <= 1'b0;
                    2'b10: pin_r <= 1'b1;
                    2'b11: pin_r <= ~pin_r;
                endcase
            end
        end
        else if (pwm_mode)
        begin
            unique case (act)
                2'b00: pin_r <= 1'b0;
                2'b01: pin_r <= 1'b1;
                2'b10:
                begin
                    if (run_rise || per_ev)
                        pin_r <= 1'b1;
                    else if (duty_ev)
                        pin_r <= 1'b0;
                end
                2'b11:
                begin
                    if (AUDIO_TYPE)
                        pin_r <= 1'b0;
                    else if (run_rise)
                        pin_r <= 1'b1;
                    else if (ev_a)
                        pin_r <= 1'b0;
                end
            endcase
        end
    end

    // Output pin pair with PWM polarity
    // inverted companion pin
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_r <= 1'b0;
            out_n_r <= 1'b1;
        end
        else
        begin
            out_r <= pin_r ^ (pwm_mode & ctrl1_r[TMCC_C1_POL]);
            out_n_r <= ~(pin_r ^ (pwm_mode & ctrl1_r[TMCC_C1_POL]));
        end
    end
    assign timer_output_pin_o = out_r;
    assign timer_output_inverted_pin_o = out_n_r;
endmodule
`default_nettype wire

// File: verification/tmcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmcc_pin_model
(
    input wire logic clk_i,
    output logic ext_o,
    output logic cap_o
);
    // Both pins rest low between bursts
    initial
    begin
        ext_o = 1'b0;
        cap_o = 1'b0;
    end

    task automatic ext_pulses(input int n, input int w);
        repeat (n)
        begin
            @(posedge clk_i);
            ext_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            ext_o <= 1'b0;
            repeat (w) @(posedge clk_i);
        end
    endtask

    // One high pulse on the capture pin
    task automatic cap_pulse(input int w);
        @(posedge clk_i);
        cap_o <= 1'b1;
        repeat (w) @(posedge clk_i);
        cap_o <= 1'b0;
        repeat (w) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: verification/tmcc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tmcc_core_chk
    import tmcc_pkg::*;
#(
    parameter bit AUDIO_TYPE = 1'b0
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_inverted_pin_o,
    input wire logic [2:0] match_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Software clear of the flag register
    logic flag_wr;
    assign flag_wr = wr_i && (addr_i == TMCC_ADDR_FLAGS);

    property p_inv_pin;
        timer_output_inverted_pin_o == !timer_output_pin_o;
    endproperty
    a_inv_pin: assert property (p_inv_pin) else $error("inverted pin not complement");
    property p_rdata_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_unmapped;
        rd_i && (addr_i > TMCC_ADDR_CTRL2) |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_flag_a_hold;
        match_flag_o[TMCC_FLAG_A] && !flag_wr && !$past(flag_wr) |=> match_flag_o[TMCC_FLAG_A];
    endproperty
    a_flag_a_hold: assert property (p_flag_a_hold) else $error("flag A dropped");
    property p_flag_p_hold;
        match_flag_o[TMCC_FLAG_P] && !flag_wr && !$past(flag_wr) |=> match_flag_o[TMCC_FLAG_P];
    endproperty
    a_flag_p_hold: assert property (p_flag_p_hold) else $error("flag P dropped");
    property p_flag_b_absent;
        AUDIO_TYPE || (match_flag_o[TMCC_FLAG_B] == 1'b0);
    endproperty
    a_flag_b_absent: assert property (p_flag_b_absent) else $error("flag B without B");
    property p_high_commit;
        wr_i && addr_i == TMCC_ADDR_A_H ##1 rd_i && addr_i == TMCC_ADDR_A_H
            |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_high_commit: assert property (p_high_commit) else $error("high byte readback");
    property p_low_buffer;
        wr_i && addr_i == TMCC_ADDR_A_L ##1 wr_i && addr_i == TMCC_ADDR_A_H
            ##1 rd_i && addr_i == TMCC_ADDR_A_H ##2 rd_i && addr_i == TMCC_ADDR_A_L
            |=> rdata_o == $past(wdata_i, 5);
    endproperty
    a_low_buffer: assert property (p_low_buffer) else $error("low byte readback");
endmodule
bind tmcc_core tmcc_core_chk #(.AUDIO_TYPE(AUDIO_TYPE)) u_chk (.clk_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .timer_output_pin_o, .timer_output_inverted_pin_o,
    .match_flag_o);
`default_nettype wire

// File: verification/tb_timer_module_common_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_module_common_core;
    import tmcc_pkg::*;
    localparam int SEL_PIN = 3;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic ext_w;
    logic cap_w;
    logic pin_w;
    logic pinb_w;
    logic [2:0] flag_w;
    int fail_count = 0;
    int comparisons = 0;
    logic [3:0] init_tab = 4'b0011;
    logic [3:0] exp_tab = 4'b1101;
    int k;

    // 40 MHz system clock
    always #12.5 clk_i = ~clk_i;

    tmcc_pin_model PIN (.clk_i(clk_i), .ext_o(ext_w), .cap_o(cap_w));
    tmcc_core #(.SUB_DIV(4)) DUT (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .external_clock_pin_i(ext_w), .capture_input_pin_i(cap_w),
        .timer_output_pin_o(pin_w), .timer_output_inverted_pin_o(pinb_w),
        .match_flag_o(flag_w));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One bus cycle; read data checked mid-cycle while it stands
    task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= w ? d : 8'h00;
        @(posedge clk_i);
        if (r)
        begin
            rd_i <= 1'b0;
            @(negedge clk_i);
            check(rdata_o, d);
            @(posedge clk_i);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, e);
    endtask

    task automatic idle();
        cyc(1'b0, 1'b0, 4'h0, 8'h00);
    endtask

    // Bounded wait on a flag bit or on the pin
    task automatic wait_for(input int sel, input logic v, input int lim);
        logic [3:0] obs;
        int i;
        for (i = 0; i < lim; i++)
        begin
            @(negedge clk_i);
            obs = {pin_w, flag_w};
            if (obs[sel] === v)
                break;
        end
        @(posedge clk_i);
        check({7'h00, obs[sel]}, {7'h00, v});
        if (i == lim)
            print_verdict();
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({7'h00, pinb_w}, 8'h01);
        rd(TMCC_ADDR_CTRL0, 8'h00);
        rd(TMCC_ADDR_FLAGS, 8'h00);
        rd(TMCC_ADDR_CNT_H, 8'h00);
        rd(TMCC_ADDR_CNT_L, 8'h00);
        wr(TMCC_ADDR_A_L, 8'h34);
        wr(TMCC_ADDR_A_H, 8'h12);
        rd(TMCC_ADDR_A_H, 8'h12);
        rd(TMCC_ADDR_A_L, 8'h34);
        wr(TMCC_ADDR_A_L, 8'h56);
        rd(TMCC_ADDR_A_H, 8'h12);
        rd(TMCC_ADDR_A_L, 8'h34);
        wr(4'hb, 8'hff);
        rd(4'hb, 8'h00);
        wr(TMCC_ADDR_CNT_L, 8'h77);
        rd(TMCC_ADDR_CNT_H, 8'h00);
        rd(TMCC_ADDR_CNT_L, 8'h00);
        wr(TMCC_ADDR_P, 8'h01);
        rd(TMCC_ADDR_P, 8'h01);
        $display("test bytes done");
        wr(TMCC_ADDR_A_L, 8'h08);
        wr(TMCC_ADDR_A_H, 8'h00);
        for (k = 0; k < 4; k++)
        begin
            wr(TMCC_ADDR_CTRL1, {2'b00, k[1:0], init_tab[k], 3'b001});
            wr(TMCC_ADDR_CTRL0, 8'h18);
            idle();
            repeat (2) @(posedge clk_i);
            check({7'h00, pin_w}, {7'h00, init_tab[k]});
            wait_for(TMCC_FLAG_A, 1'b1, 40);
            repeat (2) @(posedge clk_i);
            check({7'h00, pin_w}, {7'h00, exp_tab[k]});
            check({7'h00, pinb_w}, {7'h00, ~exp_tab[k]});
            wr(TMCC_ADDR_CTRL0, 8'h10);
            wr(TMCC_ADDR_FLAGS, 8'h01);
            rd(TMCC_ADDR_FLAGS, 8'h00);
        end
        $display("test compare done");
        for (k = 0; k < 2; k++)
        begin
            wr(TMCC_ADDR_CTRL1, 8'hc0);
            wr(TMCC_ADDR_CTRL0, (k == 0) ? 8'h60 : 8'h70);
            wr(TMCC_ADDR_CTRL0, (k == 0) ? 8'h68 : 8'h78);
            idle();
            PIN.ext_pulses(5, 4);
            repeat (6) @(posedge clk_i);
            rd(TMCC_ADDR_CNT_H, 8'h00);
            rd(TMCC_ADDR_CNT_L, 8'h05);
            idle();
        end
        $display("test pin clock done");
        for (k = 0; k < 4; k++)
        begin
            wr(TMCC_ADDR_CTRL1, {2'b01, k[1:0], 4'h0});
            wr(TMCC_ADDR_CTRL0, 8'h60);
            wr(TMCC_ADDR_CTRL0, 8'h68);
            idle();
            PIN.ext_pulses(k + 2, 4);
            PIN.cap_pulse(4);
            repeat (6) @(posedge clk_i);
            rd(TMCC_ADDR_A_H, 8'h00);
            rd(TMCC_ADDR_A_L, (k < 3) ? 8'(k + 2) : 8'h04);
        end
        $display("test capture done");
        wr(TMCC_ADDR_CTRL1, 8'hc0);
        wr(TMCC_ADDR_CTRL0, 8'h10);
        wr(TMCC_ADDR_FLAGS, 8'h07);
        wr(TMCC_ADDR_CTRL0, 8'h18);
        idle();
        wait_for(TMCC_FLAG_P, 1'b1, 400);
        wr(TMCC_ADDR_CTRL0, 8'h10);
        wr(TMCC_ADDR_FLAGS, 8'h07);
        rd(TMCC_ADDR_FLAGS, 8'h00);
        $display("test period match done");
        wr(TMCC_ADDR_A_L, 8'h20);
        wr(TMCC_ADDR_A_H, 8'h00);
        wr(TMCC_ADDR_CTRL1, 8'hb0);
        idle();
        PIN.ext_pulses(1, 4);
        wait_for(SEL_PIN, 1'b1, 4);
        wait_for(SEL_PIN, 1'b0, 60);
        rd(TMCC_ADDR_CTRL0, 8'h10);
        $display("test single pulse done");
        wr(TMCC_ADDR_A_L, 8'h80);
        wr(TMCC_ADDR_A_H, 8'h00);
        wr(TMCC_ADDR_CTRL1, 8'ha0);
        wr(TMCC_ADDR_CTRL0, 8'h18);
        idle();
        wait_for(SEL_PIN, 1'b1, 8);
        wait_for(SEL_PIN, 1'b0, 200);
        wait_for(SEL_PIN, 1'b1, 200);
        wr(TMCC_ADDR_CTRL0, 8'h10);
        idle();
        $display("test pwm done");
        print_verdict();
    end
endmodule
`default_nettype wire
